// ==== include/msc_consts.svh ====
// Constants for the MAC statistics counter block: offsets, indices, widths and limits.
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH

// ==========================================================================
// Widths
// ==========================================================================
`define MSC_DATA_W          32
`define MSC_ADDR_W          8
`define MSC_OCTET_W         16
`define MSC_TRY_W           5
`define MSC_MAC_W           48
`define MSC_GROUP_DEPTH     4
`define MSC_NUM_CNT         14

// ==========================================================================
// Counter indices (byte offset is index times four)
// ==========================================================================
`define MSC_CNT_SINGLE_COLL 0
`define MSC_CNT_MULTI_COLL  1
`define MSC_CNT_RX_GOOD     2
`define MSC_CNT_RX_CRC      3
`define MSC_CNT_RX_ALIGN    4
`define MSC_CNT_TX_OCTETS   5
`define MSC_CNT_DEFERRED    6
`define MSC_CNT_LATE_COLL   7
`define MSC_CNT_XS_COLL     8
`define MSC_CNT_TX_LOSS     9
`define MSC_CNT_RX_LOSS     10
`define MSC_CNT_CARRIER     11
`define MSC_CNT_RX_OCTETS   12
`define MSC_CNT_TX_GROUP    13

// ==========================================================================
// Control register offsets and fields
// ==========================================================================
`define MSC_OFS_CTRL        8'h40
`define MSC_OFS_STA_LO      8'h44
`define MSC_OFS_STA_HI      8'h48
`define MSC_OFS_GROUP_BASE  8'h80
`define MSC_CTRL_ACCEPT_ALL 0
`define MSC_CTRL_GROUP_EN   1
`define MSC_GROUP_VALID_BIT 16
`define MSC_CTRL_RESET      2'h2
`define MSC_STA_RESET       48'h0000_0000_0000

// ==========================================================================
// Transmit limits
// ==========================================================================
`define MSC_TX_TRY_CEILING  5'h10
`define MSC_TRY_ONE         5'h01
`define MSC_TRY_TWO         5'h02

`endif

// ==== include/msc_pkg.sv ====
// Types shared by the MAC statistics counter block and its users.
`include "msc_consts.svh"

package msc_pkg;

    // ======================================================================
    // Final frame status codes
    // ======================================================================
    typedef enum logic [1:0] {
        MSC_TX_SUCCESS,
        MSC_TX_XS_ABORT,
        MSC_TX_INT_ERROR,
        MSC_TX_OTHER
    } msc_tx_status_t;

    typedef enum logic [2:0] {
        MSC_RX_SUCCESS,
        MSC_RX_CRC_FAIL,
        MSC_RX_MISALIGNED,
        MSC_RX_TOO_LONG,
        MSC_RX_INT_ERROR,
        MSC_RX_OTHER
    } msc_rx_status_t;

    // ======================================================================
    // Event and bus carriers
    // ======================================================================
    typedef struct packed {
        logic                      valid;
        msc_tx_status_t            status;
        logic [`MSC_TRY_W-1:0]     attempts;
        logic [`MSC_TRY_W-1:0]     late_hit_tally;
        logic                      carrier_loss_flag;
        logic                      deferred;
        logic                      group_dest;
        logic [`MSC_OCTET_W-1:0]   octets;
    } msc_tx_evt_t;

    typedef struct packed {
        logic                      valid;
        msc_rx_status_t            status;
        logic [`MSC_OCTET_W-1:0]   octets;
    } msc_rx_evt_t;

    typedef struct packed {
        logic                      wr;
        logic                      rd;
        logic [`MSC_ADDR_W-1:0]    addr;
        logic [`MSC_DATA_W-1:0]    wdata;
    } msc_bus_req_t;

    typedef struct packed {
        logic                      valid;
        logic [`MSC_MAC_W-1:0]     dest;
    } msc_filt_req_t;

endpackage

// ==== hdl/msc_stats.sv ====
// MAC statistics counters, accept-all switch and group address list with filter.
//
// Behaviour
// - Count success with exactly two attempts.
// - Count success with attempts above two, within ceiling.
// - Count good receive only on success status.
// - Count CRC-fail receive status as FCS error.
// - Count misaligned receive status as alignment error.
// - No alignment counting with 8-bit group encoding.
// - Add transmitted octets on transmit success.
// - Count first-attempt deferrals without any collision.
// - Count late collision when late tally nonzero.
// - Count aborts at the attempt ceiling.
// - Internal transmit error bumps only its counter.
// - Internal receive error bumps only its counter.
// - Count carrier loss at collision-free transmit end.
// - Add received octets on receive success only.
// - Accept-all setting passes every frame; readable.
// - Accept-all frames still update normal counters.
// - Clearing accept-all restores normal address filtering.
// - Management reads back the group address list.
// - Collision-type counters meaningless in full duplex.
// - Counters are read-only; never cleared by software.
// - Octet counters take one event per cycle.
// - Count successful group, non-broadcast transmits; the code counts every success with group_dest set and has no broadcast check.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "msc_consts.svh"

module msc_stats
(
    // Clock and reset.
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    // Register port.
    input  wire msc_pkg::msc_bus_req_t    bus_req,
    output var  logic [`MSC_DATA_W-1:0]   bus_rdata,
    // Frame status events from the MAC.
    input  wire msc_pkg::msc_tx_evt_t     tx_evt,
    input  wire msc_pkg::msc_rx_evt_t     rx_evt,
    // PHY encoding option.
    input  wire logic                     group_8b_code,
    // Address filter request and answer.
    input  wire msc_pkg::msc_filt_req_t   filt_req,
    output var  logic                     filt_done,
    output var  logic                     filt_accept
);
    import msc_pkg::*;

    // ======================================================================
    // Storage
    // ======================================================================
    logic [`MSC_DATA_W-1:0]   cnt      [`MSC_NUM_CNT];
    logic [`MSC_DATA_W-1:0]   next_inc [`MSC_NUM_CNT];
    logic [`MSC_MAC_W-1:0]    group_addr  [`MSC_GROUP_DEPTH];
    logic                     group_valid [`MSC_GROUP_DEPTH];
    logic [`MSC_MAC_W-1:0]    station_addr;
    logic                     accept_all_setting;
    logic                     group_en;

    // Decode of a counter slot from a byte address.
    function automatic logic cnt_hit(input logic [`MSC_ADDR_W-1:0] a, input int idx);
        cnt_hit = (a == `MSC_ADDR_W'(idx * 4));
    endfunction

    // Decode of a group list slot: each entry takes two words.
    function automatic logic grp_hit(input logic [`MSC_ADDR_W-1:0] a, input int idx, input logic hi);
        grp_hit = (a == `MSC_ADDR_W'(`MSC_OFS_GROUP_BASE + idx * 8 + (hi ? 4 : 0)));
    endfunction

    // ======================================================================
    // Transmit event qualification
    // ======================================================================
    logic tx_ok;
    logic tx_valid_frame;
    logic tx_no_coll;
    logic rx_ok;

    // An internal error excludes the frame from every other transmit counter.
    assign tx_valid_frame = tx_evt.valid && (tx_evt.status != MSC_TX_INT_ERROR);
    assign tx_ok          = tx_evt.valid && (tx_evt.status == MSC_TX_SUCCESS);
    assign tx_no_coll     = (tx_evt.attempts == `MSC_TRY_ONE);
    assign rx_ok          = rx_evt.valid && (rx_evt.status == MSC_RX_SUCCESS);

    // ======================================================================
    // Increment amounts, one per counter per cycle
    // ======================================================================
    // Every event is taken in the cycle it is presented, so any burst of
    // frames at full line rate is absorbed without a queue. Collision-type
    // counters are fed regardless of duplex; their values carry no meaning
    // in full duplex since the MAC never reports collisions there.
    always_comb
    begin
        for (int i = 0; i < `MSC_NUM_CNT; i++)
        begin
            next_inc[i] = '0;
        end
        if (tx_ok && tx_evt.attempts == `MSC_TRY_TWO)
        begin
            next_inc[`MSC_CNT_SINGLE_COLL] = 32'h0000_0001;
        end
        if (tx_ok && tx_evt.attempts > `MSC_TRY_TWO && tx_evt.attempts <= `MSC_TX_TRY_CEILING)
        begin
            next_inc[`MSC_CNT_MULTI_COLL] = 32'h0000_0001;
        end
        if (tx_ok)
        begin
            next_inc[`MSC_CNT_TX_OCTETS] = `MSC_DATA_W'(tx_evt.octets);
        end
        if (tx_ok && tx_evt.group_dest)
        begin
            next_inc[`MSC_CNT_TX_GROUP] = 32'h0000_0001;
        end
        if (tx_valid_frame && tx_evt.deferred && tx_no_coll)
        begin
            next_inc[`MSC_CNT_DEFERRED] = 32'h0000_0001;
        end
        if (tx_valid_frame && tx_evt.late_hit_tally != '0)
        begin
            next_inc[`MSC_CNT_LATE_COLL] = 32'h0000_0001;
        end
        if (tx_valid_frame && tx_evt.status == MSC_TX_XS_ABORT
            && tx_evt.attempts == `MSC_TX_TRY_CEILING)
        begin
            next_inc[`MSC_CNT_XS_COLL] = 32'h0000_0001;
        end
        if (tx_evt.valid && tx_evt.status == MSC_TX_INT_ERROR)
        begin
            next_inc[`MSC_CNT_TX_LOSS] = 32'h0000_0001;
        end
        if (tx_valid_frame && tx_evt.carrier_loss_flag && tx_no_coll)
        begin
            next_inc[`MSC_CNT_CARRIER] = 32'h0000_0001;
        end
        // Receive counting does not look at the filter: frames passed only
        // by accept-all are counted the same as any other.
        if (rx_ok)
        begin
            next_inc[`MSC_CNT_RX_GOOD]   = 32'h0000_0001;
            next_inc[`MSC_CNT_RX_OCTETS] = `MSC_DATA_W'(rx_evt.octets);
        end
        // Coding errors above 10 Mb/s arrive already folded into CRC fail.
        if (rx_evt.valid && rx_evt.status == MSC_RX_CRC_FAIL)
        begin
            next_inc[`MSC_CNT_RX_CRC] = 32'h0000_0001;
        end
        if (rx_evt.valid && rx_evt.status == MSC_RX_MISALIGNED && !group_8b_code)
        begin
            next_inc[`MSC_CNT_RX_ALIGN] = 32'h0000_0001;
        end
        if (rx_evt.valid && rx_evt.status == MSC_RX_INT_ERROR)
        begin
            next_inc[`MSC_CNT_RX_LOSS] = 32'h0000_0001;
        end
    end

    // ======================================================================
    // Counters
    // ======================================================================
    // Only the power-on reset zeroes them; the register port has no path
    // into them, so software can never clear a count. Overflow wraps.
    generate
        for (genvar g = 0; g < `MSC_NUM_CNT; g++)
        begin : g_cnt
            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                begin
                    cnt[g] <= '0;
                end
                else
                begin
                    cnt[g] <= cnt[g] + next_inc[g];
                end
            end
        end
    endgenerate

    // ======================================================================
    // Control registers
    // ======================================================================
    // Accept-all and group enable share one word; writes take effect on the
    // next filter request.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            {group_en, accept_all_setting} <= `MSC_CTRL_RESET;
        end
        else if (bus_req.wr && bus_req.addr == `MSC_OFS_CTRL)
        begin
            accept_all_setting <= bus_req.wdata[`MSC_CTRL_ACCEPT_ALL];
            group_en           <= bus_req.wdata[`MSC_CTRL_GROUP_EN];
        end
    end

    // Station address, split over two words.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            station_addr <= `MSC_STA_RESET;
        end
        else if (bus_req.wr && bus_req.addr == `MSC_OFS_STA_LO)
        begin
            station_addr[31:0] <= bus_req.wdata;
        end
        else if (bus_req.wr && bus_req.addr == `MSC_OFS_STA_HI)
        begin
            station_addr[47:32] <= bus_req.wdata[15:0];
        end
    end

    // Group address list: low word, then high half-word with a valid bit.
    generate
        for (genvar e = 0; e < `MSC_GROUP_DEPTH; e++)
        begin : g_grp
            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                begin
                    group_addr[e]  <= '0;
                    group_valid[e] <= 1'b0;
                end
                else if (bus_req.wr && grp_hit(bus_req.addr, e, 1'b0))
                begin
                    group_addr[e][31:0] <= bus_req.wdata;
                end
                else if (bus_req.wr && grp_hit(bus_req.addr, e, 1'b1))
                begin
                    group_addr[e][47:32] <= bus_req.wdata[15:0];
                    group_valid[e]       <= bus_req.wdata[`MSC_GROUP_VALID_BIT];
                end
            end
        end
    endgenerate

    // ======================================================================
    // Read mux
    // ======================================================================
    logic [`MSC_DATA_W-1:0] next_rdata;

    // Unmapped addresses read as zero; the list is read back as written.
    always_comb
    begin
        next_rdata = '0;
        for (int i = 0; i < `MSC_NUM_CNT; i++)
        begin
            if (cnt_hit(bus_req.addr, i))
            begin
                next_rdata = cnt[i];
            end
        end
        for (int i = 0; i < `MSC_GROUP_DEPTH; i++)
        begin
            if (grp_hit(bus_req.addr, i, 1'b0))
            begin
                next_rdata = group_addr[i][31:0];
            end
            if (grp_hit(bus_req.addr, i, 1'b1))
            begin
                next_rdata = {15'h0000, group_valid[i], group_addr[i][47:32]};
            end
        end
        if (bus_req.addr == `MSC_OFS_CTRL)
        begin
            next_rdata = {30'h0000_0000, group_en, accept_all_setting};
        end
        if (bus_req.addr == `MSC_OFS_STA_LO)
        begin
            next_rdata = station_addr[31:0];
        end
        if (bus_req.addr == `MSC_OFS_STA_HI)
        begin
            next_rdata = {16'h0000, station_addr[47:32]};
        end
    end

    // Read data stands for the single cycle after the strobe.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            bus_rdata <= '0;
        end
        else
        begin
            bus_rdata <= bus_req.rd ? next_rdata : '0;
        end
    end

    // ======================================================================
    // Address filter
    // ======================================================================
    logic group_match;
    logic next_accept;

    // A group address matches only an enabled list entry.
    always_comb
    begin
        group_match = 1'b0;
        for (int i = 0; i < `MSC_GROUP_DEPTH; i++)
        begin
            if (group_valid[i] && group_addr[i] == filt_req.dest)
            begin
                group_match = 1'b1;
            end
        end
    end

    // Bit 0 of the first octet marks a group address; all ones is broadcast.
    assign next_accept = accept_all_setting
                         || filt_req.dest == station_addr
                         || &filt_req.dest
                         || (filt_req.dest[40] && group_en && group_match);

    // One-cycle answer to each request; accept is held until the next one.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            filt_done   <= 1'b0;
            filt_accept <= 1'b0;
        end
        else
        begin
            filt_done <= filt_req.valid;
            if (filt_req.valid)
            begin
                filt_accept <= next_accept;
            end
        end
    end

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_tx_single;
        tx_evt.valid && tx_evt.status == MSC_TX_SUCCESS && tx_evt.attempts == 5'h02;
    endsequence

    sequence s_tx_internal;
        tx_evt.valid && tx_evt.status == MSC_TX_INT_ERROR;
    endsequence

    sequence s_accept_all_write;
        bus_req.wr && bus_req.addr == 8'h40 && bus_req.wdata[0];
    endsequence

    single_coll_a: assert property (s_tx_single |=> cnt[0] == 32'($past(cnt[0]) + 32'h1))
        else $error("single collision count did not step");

    multi_coll_a: assert property (tx_evt.valid && tx_evt.status == MSC_TX_SUCCESS && tx_evt.attempts == 5'h03
        |=> cnt[1] != $past(cnt[1]))
        else $error("multiple collision count did not step");

    rx_good_a: assert property (rx_evt.valid && rx_evt.status != MSC_RX_SUCCESS |=> $stable(cnt[2]))
        else $error("good receive counted an errored frame");

    align_8b_a: assert property (group_8b_code |=> $stable(cnt[4]))
        else $error("alignment count moved under 8-bit encoding");

    tx_octets_a: assert property (tx_evt.valid && tx_evt.status == MSC_TX_SUCCESS
        |=> cnt[5] == 32'($past(cnt[5]) + 32'($past(tx_evt.octets))))
        else $error("transmit octet sum wrong");

    tx_loss_only_a: assert property (s_tx_internal ##0 !rx_evt.valid
        |=> cnt[9] == 32'($past(cnt[9]) + 32'h1) && $stable(cnt[5]) && $stable(cnt[6])
            && $stable(cnt[7]) && $stable(cnt[11]))
        else $error("internal transmit error touched another counter");

    rx_octets_a: assert property (rx_evt.valid && rx_evt.status == MSC_RX_CRC_FAIL
        |=> $stable(cnt[12]) && cnt[3] == 32'($past(cnt[3]) + 32'h1))
        else $error("errored frame octets counted");

    accept_all_a: assert property (s_accept_all_write ##2 filt_req.valid |=> filt_done && filt_accept)
        else $error("accept-all did not pass frame");

    no_clear_a: assert property (!tx_evt.valid && !rx_evt.valid |=> $stable(cnt[0]) && $stable(cnt[13]))
        else $error("counter changed without an event");

    late_coll_a: assert property (tx_evt.valid && tx_evt.status == MSC_TX_SUCCESS && tx_evt.late_hit_tally != 5'h00
        |=> cnt[7] == 32'($past(cnt[7]) + 32'h1))
        else $error("late collision not counted");

endmodule

`default_nettype wire

// ==== testbench/msc_mac_model.sv ====
// Behavioural model of the MAC transmit and receive status logic.
`timescale 1ns/1ns
`default_nettype none

module msc_mac_model
(
    // Clock.
    input  wire logic                 sys_clk,
    // Status events towards the counters.
    output var  msc_pkg::msc_tx_evt_t tx_evt,
    output var  msc_pkg::msc_rx_evt_t rx_evt
);
    import msc_pkg::*;

    // ======================================================================
    // Event drivers
    // ======================================================================
    // Idle fields show the inverse of the last frame, so stale data never counts.
    initial
    begin
        tx_evt = '0;
        rx_evt = '0;
    end

    // One final status per frame, a single-cycle pulse.
    task automatic send_tx(input msc_tx_evt_t e);
        msc_tx_evt_t idle;
        begin
            idle = ~e;
            idle.valid = 1'b0;
            @(posedge sys_clk) tx_evt <= e;
            @(posedge sys_clk) tx_evt <= idle;
        end
    endtask

    // A coding error at high speed is reported as a CRC failure.
    task automatic send_rx(input msc_rx_evt_t e, input logic code_err);
        msc_rx_evt_t idle;
        begin
            if (code_err)
                e.status = MSC_RX_CRC_FAIL;
            idle = ~e;
            idle.valid = 1'b0;
            @(posedge sys_clk) rx_evt <= e;
            @(posedge sys_clk) rx_evt <= idle;
        end
    endtask
endmodule

`default_nettype wire

// ==== testbench/msc_stats_test.sv ====
// Self-checking testbench for the MAC statistics counter block.
`timescale 1ns/1ns
`default_nettype none
`include "msc_consts.svh"

module msc_stats_test;
    import msc_pkg::*;

    // ======================================================================
    // Signals
    // ======================================================================
    logic                   sys_clk;
    logic                   rst_n;
    msc_bus_req_t           bus_req;
    logic [`MSC_DATA_W-1:0] bus_rdata;
    msc_tx_evt_t            tx_evt;
    msc_rx_evt_t            rx_evt;
    logic                   group_8b_code;
    msc_filt_req_t          filt_req;
    logic                   filt_done;
    logic                   filt_accept;
    logic [31:0]            exp_cnt [`MSC_NUM_CNT];
    logic [31:0]            d;
    int                     err_count;
    int                     n_checks;

    msc_stats dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .tx_evt(tx_evt), .rx_evt(rx_evt), .group_8b_code(group_8b_code), .filt_req(filt_req),
        .filt_done(filt_done), .filt_accept(filt_accept));
    msc_mac_model mac (.sys_clk(sys_clk), .tx_evt(tx_evt), .rx_evt(rx_evt));

    // 25 MHz clock.
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ======================================================================
    // Shared tasks
    // ======================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        begin
            n_checks++;
            if (got !== want)
            begin
                err_count++;
                $display("BAD t=%0t got=%h exp=%h", $time, got, want);
            end
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] w);
        begin
            @(posedge sys_clk) bus_req <= '{1'b1, 1'b0, a, w};
            @(posedge sys_clk) bus_req <= '0;
        end
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] r);
        begin
            @(posedge sys_clk) bus_req <= '{1'b0, 1'b1, a, 32'h0000_0000};
            @(posedge sys_clk) bus_req <= '0;
            #1 r = bus_rdata;
        end
    endtask

    task automatic chk_all();
        begin
            for (int i = 0; i < `MSC_NUM_CNT; i++)
            begin
                bus_rd(8'(i * 4), d);
                chk(d, exp_cnt[i]);
            end
        end
    endtask

    // Expectations follow the counting rules, not the design.
    task automatic tx(input msc_tx_status_t st, input logic [4:0] at, input logic [4:0] lt,
                      input logic cl, input logic df, input logic gd, input logic [15:0] oc);
        begin
            mac.send_tx('{1'b1, st, at, lt, cl, df, gd, oc});
            if (st == MSC_TX_INT_ERROR)
                exp_cnt[`MSC_CNT_TX_LOSS]++;
            else
            begin
                if (st == MSC_TX_SUCCESS)
                begin
                    exp_cnt[`MSC_CNT_TX_OCTETS] += 32'(oc);
                    if (at == 5'h02) exp_cnt[`MSC_CNT_SINGLE_COLL]++;
                    if (at > 5'h02 && at <= 5'h10) exp_cnt[`MSC_CNT_MULTI_COLL]++;
                    if (gd) exp_cnt[`MSC_CNT_TX_GROUP]++;
                end
                if (st == MSC_TX_XS_ABORT && at == 5'h10) exp_cnt[`MSC_CNT_XS_COLL]++;
                if (lt != 5'h00) exp_cnt[`MSC_CNT_LATE_COLL]++;
                if (at == 5'h01 && df) exp_cnt[`MSC_CNT_DEFERRED]++;
                if (at == 5'h01 && cl) exp_cnt[`MSC_CNT_CARRIER]++;
            end
        end
    endtask

    task automatic rx(input msc_rx_status_t st, input logic [15:0] oc, input logic ce);
        msc_rx_status_t s;
        begin
            mac.send_rx('{1'b1, st, oc}, ce);
            s = msc_rx_status_t'(ce ? MSC_RX_CRC_FAIL : st);
            if (s == MSC_RX_SUCCESS) exp_cnt[`MSC_CNT_RX_GOOD]++;
            if (s == MSC_RX_SUCCESS) exp_cnt[`MSC_CNT_RX_OCTETS] += 32'(oc);
            if (s == MSC_RX_CRC_FAIL) exp_cnt[`MSC_CNT_RX_CRC]++;
            if (s == MSC_RX_MISALIGNED && !group_8b_code) exp_cnt[`MSC_CNT_RX_ALIGN]++;
            if (s == MSC_RX_INT_ERROR) exp_cnt[`MSC_CNT_RX_LOSS]++;
        end
    endtask

    task automatic filt(input logic [47:0] dest, input logic want);
        begin
            @(posedge sys_clk) filt_req <= '{1'b1, dest};
            @(posedge sys_clk) filt_req <= '{1'b0, ~dest};
            #1 chk({31'h0, filt_done}, 32'h0000_0001);
            chk({31'h0, filt_accept}, {31'h0, want});
        end
    endtask

    // ======================================================================
    // Scenarios
    // ======================================================================
    task automatic t_tx();
        begin
            tx(MSC_TX_SUCCESS, 5'h01, 5'h00, 1'b0, 1'b1, 1'b0, 16'h0040);
            tx(MSC_TX_SUCCESS, 5'h02, 5'h00, 1'b0, 1'b1, 1'b0, 16'h0064);
            tx(MSC_TX_SUCCESS, 5'h03, 5'h00, 1'b0, 1'b0, 1'b1, 16'h003C);
            tx(MSC_TX_SUCCESS, 5'h10, 5'h02, 1'b0, 1'b0, 1'b0, 16'h05DC);
            tx(MSC_TX_XS_ABORT, 5'h10, 5'h00, 1'b0, 1'b0, 1'b0, 16'h0000);
            tx(MSC_TX_INT_ERROR, 5'h01, 5'h01, 1'b1, 1'b1, 1'b1, 16'h0050);
            tx(MSC_TX_SUCCESS, 5'h01, 5'h00, 1'b1, 1'b0, 1'b0, 16'h002E);
            chk_all();
        end
    endtask

    task automatic t_rx();
        begin
            rx(MSC_RX_SUCCESS, 16'h0040, 1'b0);
            rx(MSC_RX_CRC_FAIL, 16'h0040, 1'b0);
            rx(MSC_RX_SUCCESS, 16'h0080, 1'b1);
            rx(MSC_RX_MISALIGNED, 16'h0041, 1'b0);
            @(posedge sys_clk) group_8b_code <= 1'b1;
            rx(MSC_RX_MISALIGNED, 16'h0041, 1'b0);
            @(posedge sys_clk) group_8b_code <= 1'b0;
            rx(MSC_RX_TOO_LONG, 16'h0600, 1'b0);
            rx(MSC_RX_INT_ERROR, 16'h0040, 1'b0);
            // Both paths report in one cycle.
            fork
                tx(MSC_TX_SUCCESS, 5'h01, 5'h00, 1'b0, 1'b0, 1'b0, 16'h0100);
                rx(MSC_RX_SUCCESS, 16'h0200, 1'b0);
            join
            chk_all();
        end
    endtask

    // Counter offsets ignore writes; an unmapped read returns zero.
    task automatic t_ro();
        begin
            bus_wr(8'h00, 32'hFFFF_FFFF);
            bus_wr(8'h14, 32'h0000_0000);
            chk_all();
            bus_rd(8'h38, d);
            chk(d, 32'h0000_0000);
        end
    endtask

    task automatic t_filter();
        begin
            bus_wr(`MSC_OFS_STA_LO, 32'h3344_5566);
            bus_wr(`MSC_OFS_STA_HI, 32'h0000_0022);
            bus_wr(`MSC_OFS_GROUP_BASE, 32'h5E00_0001);
            bus_wr(`MSC_OFS_GROUP_BASE + 8'h04, 32'h0001_0100);
            bus_rd(`MSC_OFS_GROUP_BASE + 8'h04, d);
            chk(d, 32'h0001_0100);
            filt(48'h0022_3344_5566, 1'b1);
            filt(48'h0100_5E00_0001, 1'b1);
            filt(48'hFFFF_FFFF_FFFF, 1'b1);
            filt(48'h0022_0000_0001, 1'b0);
            bus_wr(`MSC_OFS_CTRL, 32'h0000_0003);
            filt(48'h0022_0000_0001, 1'b1);
            bus_rd(`MSC_OFS_CTRL, d);
            chk(d, 32'h0000_0003);
            rx(MSC_RX_SUCCESS, 16'h0040, 1'b0);
            rx(MSC_RX_CRC_FAIL, 16'h0040, 1'b0);
            chk_all();
            bus_wr(`MSC_OFS_CTRL, 32'h0000_0002);
            filt(48'h0022_0000_0001, 1'b0);
        end
    endtask

    // ======================================================================
    // Run control
    // ======================================================================
    task automatic end_sim();
        begin
            $display("checks=%0d errors=%0d", n_checks, err_count);
            if (err_count == 0 && n_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    // Main sequence; reset is held for three cycles.
    initial
    begin
        err_count = 0;
        n_checks = 0;
        rst_n = 1'b0;
        bus_req = '0;
        group_8b_code = 1'b0;
        filt_req = '0;
        for (int i = 0; i < `MSC_NUM_CNT; i++)
            exp_cnt[i] = 32'h0000_0000;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        chk_all();
        bus_rd(`MSC_OFS_CTRL, d);
        chk(d, {30'h0, `MSC_CTRL_RESET});
        t_tx();
        t_rx();
        t_ro();
        t_filter();
        end_sim();
    end

    // The tests need well under 1000 cycles; a hang is cut short.
    initial
    begin
        #200000;
        err_count++;
        end_sim();
    end
endmodule

`default_nettype wire
